// >>> verilog/card_task_queue_executor.sv
// card-side task queue: submission, readiness, execution, abort, error reporting
`timescale 1ns/10ps
`default_nettype none
module card_task_queue_executor
   import queue_pkg::*;
#(
   parameter int QDEPTH = 32,
   parameter logic [31:0] CAP_BLOCKS = 32'hFFFF_FFFF,
   parameter int unsigned READY_CYC = READY_CYC_DEF,
   parameter int unsigned READ_CYC = READ_CYC_DEF,
   parameter int unsigned WR_CYC = WR_CYC_DEF,
   parameter int unsigned WR_HC_CYC = WR_HC_CYC_DEF
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic link_clk_i,
   input wire logic blk_done_i,
   input wire logic mem_err_i,
   input wire logic corr_fail_i,
   input wire logic wp_i,
   output logic xfer_active_o,
   output logic xfer_read_o,
   output logic xfer_go_o,
   output logic [ID_W-1:0] xfer_id_o,
   output logic [ADR_W-1:0] xfer_addr_o,
   output logic [CNT_W-1:0] xfer_left_o,
   output logic [11:0] blk_len_o
);
   localparam int NT = 2**ID_W;

   seq_e state_r;
   logic ack_r, req, wr, cmd_wr, chk, cq_off;
   logic [7:0] off;
   logic [5:0] cmd_r;
   logic [31:0] arg_r, resp_r, stat_w;
   logic ans_r, cq_en_r, seq_r, hc_r;
   logic [11:0] blklen_r;
   logic [NT-1:0] valid_r, ready_r, errmap_r, set_m, clr_m, rdy_m, err_m;
   logic pend_r, p_dir_r;
   logic [ID_W-1:0] p_id_r;
   logic [CNT_W-1:0] p_cnt_r;
   logic ill_pend_r, err_pend_r, corr_pend_r;
   logic [ID_W-1:0] a_id;
   logic [ENT_W-1:0] rd_w;
   logic [5:0] low_valid, low_wait;
   logic [ADR_W:0] end_blk;
   logic d_ok, d_ill, d_gerr, d_rng, d_wp, d_q44, d_sub, d_exec, d_xerr, d_all, d_one, d_stop;
   logic xf_act_r, xf_rd_r, xf_go_r;
   logic [ID_W-1:0] xf_id_r;
   logic [ADR_W-1:0] xf_addr_r;
   logic [CNT_W-1:0] xf_left_r;
   logic lk_s1, lk_s2, lk_s3, bd_s1, bd_s2, blk_ev, blk_last, xf_done;
   logic rdy_done, prep_done, wr_to;

   // lowest set bit of a task vector as {found, id}
   function automatic logic [5:0] first_set(input logic [NT-1:0] v);
      logic [5:0] r;
      r = '0;
      for (int i = NT - 1; i >= 0; i--)
         if (v[i])
            r = {1'b1, ID_W'(i)};
      return r;
   endfunction : first_set

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave: one wait state, ack dropped the cycle after it rose
   assign off = {adr_i[7:2], 2'b00};
   assign req = cyc_i & stb_i & ~ack_r;
   assign wr = req & we_i;
   assign ack_o = ack_r;
   assign cmd_wr = wr & sel_i[0] & (off == OFF_CMD) & (state_r == S_IDLE);
   assign cq_off = wr & sel_i[0] & (off == OFF_CTRL) & cq_en_r & ~dat_i[CTRL_EN];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_r <= 1'b0;
      else
         ack_r <= req;
   end

   // read mux; unmapped offsets read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= '0;
      else if (req && !we_i)
      begin
         unique case (off)
            OFF_CMD: dat_o <= {26'h0, cmd_r};
            OFF_ARG: dat_o <= arg_r;
            OFF_RESP: dat_o <= resp_r;
            OFF_INFO: dat_o <= {18'h0, cmd_r, 6'h0, ans_r, state_r != S_IDLE};
            OFF_READY: dat_o <= ready_r;
            OFF_CTRL: dat_o <= {29'h0, hc_r, seq_r, cq_en_r};
            OFF_TERR: dat_o <= errmap_r;
            OFF_XFER: dat_o <= {xf_left_r, 8'h0, xf_id_r, xf_go_r, xf_rd_r, xf_act_r};
            default: dat_o <= '0;
         endcase
      end
   end

   // argument register honours byte lanes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         arg_r <= '0;
      else if (wr && off == OFF_ARG)
         for (int b = 0; b < 4; b++)
            if (sel_i[b])
               arg_r[8*b +: 8] <= dat_i[8*b +: 8];
   end

   // mode control; block length from the length command is kept across queue mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cq_en_r <= 1'b0;
         seq_r <= 1'b0;
         hc_r <= 1'b0;
         blklen_r <= BLK_LEN_RST;
      end
      else
      begin
         if (wr && sel_i[0] && off == OFF_CTRL)
         begin
            cq_en_r <= dat_i[CTRL_EN];
            seq_r <= dat_i[CTRL_SEQ];
            hc_r <= dat_i[CTRL_HC];
         end
         if (chk && cmd_r == CMD_BLKLEN && !cq_en_r)
            blklen_r <= arg_r[11:0];
      end
   end
   assign blk_len_o = cq_en_r ? QUEUE_BLK_LEN : blklen_r;

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer: latch, look up the task entry, then decide
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= S_IDLE;
         cmd_r <= '0;
      end
      else
      begin
         unique case (state_r)
            S_IDLE:
               if (cmd_wr)
               begin
                  cmd_r <= dat_i[5:0];
                  state_r <= S_LOOK;
               end
            S_LOOK: state_r <= S_CHECK;
            S_CHECK: state_r <= S_IDLE;
         endcase
      end
   end

   assign chk = (state_r == S_CHECK);
   assign a_id = arg_r[ARG_ID +: ID_W];
   assign low_valid = first_set(valid_r);
   assign low_wait = first_set(valid_r & ~ready_r);
   assign end_blk = {1'b0, rd_w[ADR_W-1:0]} + {{(ADR_W+1-CNT_W){1'b0}}, rd_w[ENT_DIR-1:ADR_W]};

   // decision for the latched command
   always_comb
   begin
      {d_ok, d_ill, d_gerr, d_rng, d_wp, d_q44, d_sub, d_exec, d_xerr, d_all, d_one, d_stop} = 12'h800;
      if (chk)
      begin
         if (!cq_en_r && cmd_r >= CMD_QMGMT && cmd_r <= CMD_EXEC_WR)
            {d_ok, d_ill} = 2'h1;
         else
         begin
            case (cmd_r)
               CMD_TPARAM:
                  if (arg_r[CNT_W-1:0] == '0 || valid_r[a_id] || 32'(a_id) >= 32'(QDEPTH))
                     {d_ok, d_ill} = 2'h1;
                  else
                     d_q44 = 1'b1;
               CMD_TADDR:
                  if (!pend_r)
                     {d_ok, d_ill} = 2'h1;
                  else
                     d_sub = 1'b1;
               CMD_EXEC_RD, CMD_EXEC_WR:
                  if (!valid_r[a_id] || rd_w[ENT_DIR] != (cmd_r == CMD_EXEC_RD) || xf_act_r ||
                      (!seq_r && !ready_r[a_id]) || (seq_r && low_valid[ID_W-1:0] != a_id))
                     {d_ok, d_ill} = 2'h1;
                  else if (end_blk > {1'b0, CAP_BLOCKS})
                     {d_rng, d_xerr} = 2'h3;
                  else if (cmd_r == CMD_EXEC_WR && wp_i)
                     {d_wp, d_xerr} = 2'h3;
                  else
                     d_exec = 1'b1;
               CMD_QMGMT:
                  if (arg_r[ARG_OP +: 4] == QM_ABORT_ALL)
                     d_all = 1'b1;
                  else if (arg_r[ARG_OP +: 4] == QM_ABORT_ONE)
                     d_one = valid_r[a_id];
                  else
                     d_gerr = 1'b1;
               CMD_STOP: d_stop = 1'b1;
               default: d_ok = 1'b1;
            endcase
         end
      end
   end

   // status word; block length fault is never raised in queue mode
   always_comb
   begin
      stat_w = '0;
      stat_w[ST_ILLEGAL] = ill_pend_r;
      stat_w[ST_ERROR] = d_gerr | err_pend_r;
      stat_w[ST_CORR_FAIL] = corr_pend_r;
      stat_w[ST_ADDR_BEYOND] = d_rng;
      stat_w[ST_WP_BREACH] = d_wp;
      stat_w[ST_BLKLEN_FAULT] = 1'b0;
   end

   // response and sticky flags; a new event beats the clear by a report
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         resp_r <= '0;
         ans_r <= 1'b0;
         ill_pend_r <= 1'b0;
         err_pend_r <= 1'b0;
         corr_pend_r <= 1'b0;
      end
      else
      begin
         if (chk)
         begin
            ans_r <= d_ok;
            if (d_ok)
               resp_r <= stat_w;
         end
         ill_pend_r <= (ill_pend_r & ~(chk & d_ok)) | d_ill;
         err_pend_r <= (err_pend_r & ~(chk & d_ok)) | mem_err_i | wr_to;
         corr_pend_r <= (corr_pend_r & ~(chk & d_ok)) | corr_fail_i;
      end
   end

   // pending parameter command, voided by any other command
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pend_r <= 1'b0;
         p_dir_r <= 1'b0;
         p_id_r <= '0;
         p_cnt_r <= '0;
      end
      else if (chk)
      begin
         pend_r <= d_q44;
         if (d_q44)
         begin
            p_dir_r <= arg_r[ARG_DIR];
            p_id_r <= a_id;
            p_cnt_r <= arg_r[CNT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-id flags and the parameter store
   always_comb
   begin
      set_m = d_sub ? NT'(1) << p_id_r : '0;
      rdy_m = rdy_done ? NT'(1) << low_wait[ID_W-1:0] : '0;
      clr_m = (d_all || cq_off) ? '1 : '0;
      if (d_one || d_xerr)
         clr_m = clr_m | (NT'(1) << a_id);
      if (xf_done)
         clr_m = clr_m | (NT'(1) << xf_id_r);
      err_m = '0;
      if (d_xerr)
         err_m = NT'(1) << a_id;
      if (wr_to || (mem_err_i && xf_act_r))
         err_m = err_m | (NT'(1) << xf_id_r);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         valid_r <= '0;
         ready_r <= '0;
         errmap_r <= '0;
      end
      else
      begin
         valid_r <= (valid_r & ~clr_m) | set_m;
         ready_r <= (ready_r & ~clr_m) | rdy_m;
         errmap_r <= (errmap_r & ~set_m) | err_m;
      end
   end

   task_store #(.DW(ENT_W), .AW(ID_W)) u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(d_sub),
      .waddr_i(p_id_r),
      .wdata_i({p_dir_r, p_cnt_r, arg_r}),
      .clr_i(clr_m),
      .raddr_i(a_id),
      .rdata_o(rd_w)
   );

   // readiness pacer runs while a queued task still waits; host may see more later
   deadline_timer #(.W(TMR_W)) u_ready (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(low_wait[ID_W] & cq_en_r),
      .limit_i(TMR_W'(READY_CYC)),
      .done_o(rdy_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link clock and block strobe pass two flops; edges found on the second
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         {lk_s1, lk_s2, lk_s3, bd_s1, bd_s2} <= '0;
      else
         {lk_s1, lk_s2, lk_s3, bd_s1, bd_s2} <= {link_clk_i, lk_s1, lk_s2, blk_done_i, bd_s1};
   end
   assign blk_ev = lk_s2 & ~lk_s3 & bd_s2 & xf_act_r & xf_go_r;
   assign blk_last = blk_ev & (xf_left_r == CNT_W'(1));
   assign xf_done = xf_act_r & (blk_last | wr_to | d_stop);

   // read preparation deadline
   deadline_timer #(.W(TMR_W)) u_prep (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(xf_act_r & xf_rd_r & ~xf_go_r),
      .limit_i(TMR_W'(READ_CYC)),
      .done_o(prep_done)
   );

   // per-block write timeout, restarted by every block
   deadline_timer #(.W(TMR_W)) u_wrto (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(xf_act_r & ~xf_rd_r & ~blk_ev),
      .limit_i(hc_r ? TMR_W'(WR_HC_CYC) : TMR_W'(WR_CYC)),
      .done_o(wr_to)
   );

   // transfer engine; aborts end it without completion
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         xf_act_r <= 1'b0;
         xf_rd_r <= 1'b0;
         xf_go_r <= 1'b0;
         xf_id_r <= '0;
         xf_addr_r <= '0;
         xf_left_r <= '0;
      end
      else if (d_exec)
      begin
         xf_act_r <= 1'b1;
         xf_rd_r <= rd_w[ENT_DIR];
         xf_go_r <= ~rd_w[ENT_DIR];
         xf_id_r <= a_id;
         xf_left_r <= rd_w[ENT_DIR-1:ADR_W];
         xf_addr_r <= rd_w[ADR_W-1:0];
      end
      else if (xf_done || clr_m[xf_id_r])
      begin
         xf_act_r <= 1'b0;
         xf_go_r <= 1'b0;
      end
      else
      begin
         if (prep_done)
            xf_go_r <= 1'b1;
         if (blk_ev)
         begin
            xf_left_r <= xf_left_r - 1'b1;
            xf_addr_r <= xf_addr_r + 1'b1;
         end
      end
   end

   assign xfer_active_o = xf_act_r;
   assign xfer_read_o = xf_rd_r;
   assign xfer_go_o = xf_go_r;
   assign xfer_id_o = xf_id_r;
   assign xfer_addr_o = xf_addr_r;
   assign xfer_left_o = xf_left_r;
endmodule : card_task_queue_executor
`default_nettype wire

// >>> verilog/queue_pkg.sv
// shared constants for the card task queue executor
package queue_pkg;
   // clock and deadlines
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned READY_MS = 250;
   localparam int unsigned READ_PREP_MS = 100;
   localparam int unsigned WR_BLK_MS = 250;
   localparam int unsigned WR_BLK_HC_MS = 500;
   localparam int unsigned READY_CYC_DEF = CLK_HZ / 1000 * READY_MS;
   localparam int unsigned READ_CYC_DEF = CLK_HZ / 1000 * READ_PREP_MS;
   localparam int unsigned WR_CYC_DEF = CLK_HZ / 1000 * WR_BLK_MS;
   localparam int unsigned WR_HC_CYC_DEF = CLK_HZ / 1000 * WR_BLK_HC_MS;
   localparam int TMR_W = 25;
   // task entry layout {dir, count, address}
   localparam int ID_W = 5;
   localparam int CNT_W = 16;
   localparam int ADR_W = 32;
   localparam int ENT_W = 1 + CNT_W + ADR_W;
   localparam int ENT_DIR = ENT_W - 1;
   // register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_ARG = 8'h04;
   localparam logic [7:0] OFF_RESP = 8'h08;
   localparam logic [7:0] OFF_INFO = 8'h0C;
   localparam logic [7:0] OFF_READY = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h14;
   localparam logic [7:0] OFF_TERR = 8'h18;
   localparam logic [7:0] OFF_XFER = 8'h1C;
   // control bits
   localparam int CTRL_EN = 0;
   localparam int CTRL_SEQ = 1;
   localparam int CTRL_HC = 2;
   // info bits
   localparam int INFO_BUSY = 0;
   localparam int INFO_ANS = 1;
   localparam int INFO_IDX = 8;
   // argument fields
   localparam int ARG_DIR = 30;
   localparam int ARG_ID = 16;
   localparam int ARG_OP = 0;
   // command indexes
   localparam logic [5:0] CMD_STOP = 6'h0C;
   localparam logic [5:0] CMD_BLKLEN = 6'h10;
   localparam logic [5:0] CMD_QMGMT = 6'h2B;
   localparam logic [5:0] CMD_TPARAM = 6'h2C;
   localparam logic [5:0] CMD_TADDR = 6'h2D;
   localparam logic [5:0] CMD_EXEC_RD = 6'h2E;
   localparam logic [5:0] CMD_EXEC_WR = 6'h2F;
   // queue management operation codes
   localparam logic [3:0] QM_ABORT_ALL = 4'h1;
   localparam logic [3:0] QM_ABORT_ONE = 4'h2;
   // card status bit positions
   localparam int ST_ADDR_BEYOND = 31;
   localparam int ST_BLKLEN_FAULT = 29;
   localparam int ST_WP_BREACH = 26;
   localparam int ST_ILLEGAL = 22;
   localparam int ST_CORR_FAIL = 21;
   localparam int ST_ERROR = 19;
   // block length in queue mode and after reset
   localparam logic [11:0] QUEUE_BLK_LEN = 12'h200;
   localparam logic [11:0] BLK_LEN_RST = 12'h200;
   // command sequencer states
   typedef enum logic [2:0] {S_IDLE = 3'b001, S_LOOK = 3'b010, S_CHECK = 3'b100} seq_e;
endpackage : queue_pkg

// >>> verilog/deadline_timer.sv
// cycle counter that pulses once each time a programmed limit is reached
`timescale 1ns/10ps
`default_nettype none
module deadline_timer
#(
   parameter int W = 25
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   output logic done_o
);
   logic [W-1:0] cnt_r;
   logic at_end;

   // limit of zero behaves like one cycle; the subtraction alone would wrap to the maximum
   assign at_end = (limit_i == '0) || (cnt_r >= limit_i - 1'b1);
   assign done_o = run_i & at_end;

   // count while running, wrap at the limit, clear when stopped
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !run_i || at_end)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end
endmodule : deadline_timer
`default_nettype wire

// >>> verilog/task_store.sv
// per-task parameter store with registered read and per-entry clear
`timescale 1ns/10ps
`default_nettype none
module task_store
#(
   parameter int DW = 49,
   parameter int AW = 5
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [2**AW-1:0] clr_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_r [2**AW];

   // a write to an entry beats its clear; a live id is never both
   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < 2**AW; i++)
      begin
         if (rst_i)
            mem_r[i] <= '0;
         else if (we_i && waddr_i == AW'(i))
            mem_r[i] <= wdata_i;
         else if (clr_i[i])
            mem_r[i] <= '0;
      end
   end

   // registered read port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= '0;
      else
         rdata_o <= mem_r[raddr_i];
   end
endmodule : task_store
`default_nettype wire

// >>> tb/queue_asserts.sv
// port checker for the card task queue executor
`timescale 1ns/10ps
`default_nettype none
module queue_asserts
#(
   parameter int unsigned READ_CYC = 10
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic xfer_active_o,
   input wire logic xfer_read_o,
   input wire logic xfer_go_o,
   input wire logic [4:0] xfer_id_o,
   input wire logic [31:0] xfer_addr_o,
   input wire logic [15:0] xfer_left_o,
   input wire logic [11:0] blk_len_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////
   // read preparation time, counted while active and not yet going
   int unsigned prep_r;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !xfer_active_o)
         prep_r <= 0;
      else if (!xfer_go_o)
         prep_r <= prep_r + 1;
   end
   ////////////////////
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged in next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_RESET_IDLE: assert property ($fell(rst_i) |-> !xfer_active_o && xfer_left_o == 16'h0 && blk_len_o == 12'h200)
      else $error("state not cleared by reset");
   AST_GO_ACTIVE: assert property (xfer_go_o |-> xfer_active_o)
      else $error("go without active task");
   AST_LEFT_START: assert property ($rose(xfer_active_o) |-> xfer_left_o != 16'h0)
      else $error("task started with zero blocks");
   AST_READ_PREP: assert property ($rose(xfer_go_o) && xfer_read_o |-> prep_r + 2 >= READ_CYC && prep_r <= READ_CYC + 2)
      else $error("read go not after preparation time");
   AST_READ_DEADLINE: assert property ($rose(xfer_active_o) && xfer_read_o |-> ##[1:40] (xfer_go_o || !xfer_active_o))
      else $error("read never ready");
   AST_WRITE_GO: assert property ($rose(xfer_active_o) && !xfer_read_o |-> ##[0:3] (xfer_go_o || !xfer_active_o))
      else $error("write not accepting data");
   AST_BLOCK_STEP: assert property (xfer_active_o && $past(xfer_active_o) && $stable(xfer_id_o) && xfer_left_o != 16'h0
      && xfer_left_o != $past(xfer_left_o) |-> xfer_left_o == $past(xfer_left_o) - 16'h1
      && xfer_addr_o == $past(xfer_addr_o) + 32'h1)
      else $error("block step wrong");
   AST_ID_HELD: assert property (xfer_active_o && $past(xfer_active_o) |-> $stable(xfer_id_o) && $stable(xfer_read_o))
      else $error("task id changed mid task");
   C_READ: cover property ($rose(xfer_go_o) && xfer_read_o);
   C_WRITE: cover property ($rose(xfer_go_o) && !xfer_read_o);
   C_DONE: cover property ($fell(xfer_active_o));
endmodule : queue_asserts
bind card_task_queue_executor queue_asserts #(.READ_CYC(READ_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .xfer_active_o(xfer_active_o), .xfer_read_o(xfer_read_o),
   .xfer_go_o(xfer_go_o), .xfer_id_o(xfer_id_o), .xfer_addr_o(xfer_addr_o), .xfer_left_o(xfer_left_o),
   .blk_len_o(blk_len_o));
`default_nettype wire

// >>> tb/link_peer.sv
// link-side block mover pacing blocks with its own clock
`timescale 1ns/10ps
`default_nettype none
module link_peer
(
   input wire logic go_i,
   input wire logic slow_i,
   output logic link_clk_o,
   output logic blk_done_o
);
   int unsigned n;
   // clock runs only inside a frame and stands low between frames
   initial
   begin
      link_clk_o = 1'b0;
      blk_done_o = 1'b0;
      n = 0;
      #7;
      forever
      begin
         #80;
         if (go_i || link_clk_o)
            link_clk_o = !link_clk_o;
         // slow mode stalls every other block; released line drops low
         if (!link_clk_o)
         begin
            n++;
            blk_done_o = go_i && (!slow_i || n[0]);
         end
      end
   end
endmodule : link_peer
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the card task queue executor
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench
   import queue_pkg::*;
;
   localparam int WR_HC_T = 60;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, mem_err = 1'b0, slow = 1'b0;
   logic hold = 1'b0, wp = 1'b0, corr = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, seed = 32'h7EE4;
   logic [31:0] rdat, xadr;
   logic ack, lclk, bdone, act, rd, go;
   logic [4:0] xid;
   logic [15:0] xleft;
   logic [11:0] blen;
   int bad_count = 0, total_checks = 0, act_n = 0;
   always #10 clk = !clk;
   card_task_queue_executor #(.READY_CYC(20), .READ_CYC(10), .WR_CYC(50), .WR_HC_CYC(WR_HC_T)) DUT (.clk_i(clk),
      .rst_i(rst), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .sel_i(4'hF), .we_i(we), .cyc_i(cyc), .stb_i(stb),
      .ack_o(ack), .link_clk_i(lclk), .blk_done_i(bdone), .mem_err_i(mem_err), .corr_fail_i(corr), .wp_i(wp),
      .xfer_active_o(act), .xfer_read_o(rd), .xfer_go_o(go), .xfer_id_o(xid), .xfer_addr_o(xadr),
      .xfer_left_o(xleft), .blk_len_o(blen));
   // hold keeps the peer silent so a write runs into its block timeout
   link_peer peer (.go_i(go & !hold), .slow_i(slow), .link_clk_o(lclk), .blk_done_o(bdone));
   // cycles the current task has stood active; read in the cycle after it ends
   always @(posedge clk)
      act_n <= act ? act_n + 1 : 0;
   ////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // parameter command argument: read flag, id, block count
   function automatic logic [31:0] par(input logic r, input logic [4:0] id, input logic [15:0] n);
      return {1'b0, r, 9'h0, id, n};
   endfunction : par
   // single classic cycle; held until ack is sampled high at a rising edge, released right after it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, output logic ans, output logic [31:0] r);
      logic [31:0] q;
      wb(1'b1, OFF_ARG, arg, q);
      wb(1'b1, OFF_CMD, {26'h0, idx}, q);
      do wb(1'b0, OFF_INFO, 32'h0, q); while (q[INFO_BUSY] !== 1'b0);
      ans = q[INFO_ANS];
      wb(1'b0, OFF_RESP, 32'h0, r);
   endtask : cmd
   task automatic wait_ready(input logic [4:0] id);
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         wb(1'b0, OFF_READY, 32'h0, q);
         n++;
      end
      while (q[id] !== 1'b1 && n < 40);
      `CHK(q[id], 1'b1)
   endtask : wait_ready
   task automatic run_out();
      logic [31:0] q;
      while (act !== 1'b0) @(posedge clk);
      wb(1'b0, OFF_READY, 32'h0, q);
      `CHK(q, 32'h0)
   endtask : run_out
   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////
   initial
   begin
      #1_000_000;
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      logic ans;
      logic [31:0] r, q, a;
      logic [4:0] id;
      logic [15:0] n;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, OFF_READY, 32'h0, q);
      `CHK(q, 32'h0)
      wb(1'b0, 8'h20, 32'h0, q);
      `CHK({q, blen}, {32'h0, 12'h200})
      cmd(CMD_BLKLEN, 32'h100, ans, r);
      `CHK(blen, 12'h100)
      wb(1'b1, OFF_CTRL, 32'h1, q);
      cmd(CMD_BLKLEN, 32'h80, ans, r);
      `CHK(blen, 12'h200)
      cmd(CMD_TPARAM, par(1'b1, 5'h03, 16'h0), ans, r);
      `CHK(ans, 1'b0)
      cmd(CMD_TADDR, 32'h40, ans, r);
      `CHK(ans, 1'b0)
      a = rnd() & 32'hFFFF;
      cmd(CMD_TPARAM, par(1'b1, 5'h03, 16'h2), ans, r);
      `CHK({ans, r[ST_ILLEGAL]}, 2'b11)
      cmd(CMD_TADDR, a, ans, r);
      `CHK(ans, 1'b1)
      cmd(CMD_TPARAM, par(1'b1, 5'h03, 16'h1), ans, r);
      `CHK(ans, 1'b0)
      wait_ready(5'h03);
      cmd(CMD_EXEC_WR, par(1'b0, 5'h03, 16'h0), ans, r);
      `CHK(ans, 1'b0)
      slow <= 1'b1;
      cmd(CMD_EXEC_RD, par(1'b0, 5'h03, 16'h0), ans, r);
      `CHK({ans, r[ST_ILLEGAL], r[ST_BLKLEN_FAULT]}, 3'b110)
      `CHK({act, rd, xid, xleft, xadr}, {2'b11, 5'h03, 16'h2, a})
      run_out();
      cmd(CMD_EXEC_RD, par(1'b0, 5'h03, 16'h0), ans, r);
      `CHK(ans, 1'b0)
      cmd(CMD_QMGMT, 32'h7, ans, r);
      `CHK({ans, r[ST_ERROR]}, 2'b11)
      cmd(CMD_QMGMT, {16'h9, 12'h0, QM_ABORT_ONE}, ans, r);
      `CHK({ans, r[ST_ERROR], r[ST_ILLEGAL]}, 3'b100)
      mem_err <= 1'b1;
      corr <= 1'b1;
      @(posedge clk);
      mem_err <= 1'b0;
      corr <= 1'b0;
      cmd(CMD_QMGMT, {16'h9, 12'h0, QM_ABORT_ONE}, ans, r);
      `CHK({r[ST_ERROR], r[ST_CORR_FAIL]}, 2'b11)
      slow <= 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         id = rnd() & 32'h1F;
         n = (rnd() & 32'h3) + 1;
         cmd(CMD_TPARAM, par(1'b0, id, n), ans, r);
         cmd(CMD_TADDR, rnd() & 32'hFFFF, ans, r);
         if (k % 2)
         begin
            cmd(CMD_QMGMT, {28'h0, QM_ABORT_ALL}, ans, r);
            wb(1'b0, OFF_READY, 32'h0, q);
            `CHK(q, 32'h0)
            cmd(CMD_EXEC_WR, par(1'b0, id, 16'h0), ans, r);
            `CHK(ans, 1'b0)
         end
         else
         begin
            wait_ready(id);
            cmd(CMD_EXEC_WR, par(1'b0, id, 16'h0), ans, r);
            `CHK(ans, 1'b1)
            run_out();
         end
      end
      // sequential mode with the longer write timeout: lowest id goes first, ready or not
      wb(1'b1, OFF_CTRL, 32'h7, q);
      cmd(CMD_TPARAM, par(1'b0, 5'h02, 16'h1), ans, r);
      cmd(CMD_TADDR, 32'h10, ans, r);
      cmd(CMD_TPARAM, par(1'b0, 5'h04, 16'h1), ans, r);
      cmd(CMD_TADDR, 32'h20, ans, r);
      cmd(CMD_EXEC_WR, par(1'b0, 5'h04, 16'h0), ans, r);
      `CHK(ans, 1'b0)
      hold <= 1'b1;
      cmd(CMD_EXEC_WR, par(1'b0, 5'h02, 16'h0), ans, r);
      `CHK(ans, 1'b1)
      while (act !== 1'b0) @(posedge clk);
      `CHK(act_n, WR_HC_T)
      cmd(CMD_EXEC_WR, par(1'b0, 5'h04, 16'h0), ans, r);
      `CHK({ans, r[ST_ERROR]}, 2'b11)
      cmd(CMD_STOP, 32'h0, ans, r);
      `CHK({ans, act}, 2'b10)
      hold <= 1'b0;
      wp <= 1'b1;
      cmd(CMD_TPARAM, par(1'b0, 5'h04, 16'h1), ans, r);
      `CHK(ans, 1'b1)
      cmd(CMD_TADDR, 32'h20, ans, r);
      cmd(CMD_EXEC_WR, par(1'b0, 5'h04, 16'h0), ans, r);
      `CHK({ans, r[ST_WP_BREACH]}, 2'b11)
      wp <= 1'b0;
      wb(1'b0, OFF_TERR, 32'h0, q);
      `CHK(q, 32'h14)
      wb(1'b1, OFF_CTRL, 32'h0, q);
      `CHK(blen, 12'h100)
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
